// ### lrcoc_ctrl.sv
// control/status registers for ringer, ring threshold, adc calibration,
// overload protection, billing-tone and receive-overload flags
// assumes: plain register port on clk, analog comparators arrive asynchronously
`timescale 1ns/1ns
`include "lrcoc_regs.svh"
module lrcoc_ctrl
  import lrcoc_pkg::*;
#(
  parameter bit HAS_PROG_RINGER = 1'b1,
  parameter bit HAS_RING_THRESH = 1'b1
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdata,
  // analog front end
  input  wire logic [15:0] ringLevel,
  input  wire logic        rxBelowGround,
  input  wire logic        billingToneIn,
  input  wire logic        calDoneIn,
  input  wire logic        offHookReq,
  // line controls
  output logic             ringerImpedanceSynth,
  output logic             ringThresholdHigh,
  output logic             ringDetect,
  output logic             calibClear,
  output logic             calibStart,
  output logic             autoCalEn,
  output logic             overloadProtectEn,
  output logic             offHookHold,
  output logic             irq
);

  // ============================================================
  // reset release
  logic [1:0] rstSync_q;
  logic       rstN;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end

  assign rstN = rstSync_q[1];

  // ============================================================
  // pin synchronisers
  logic [2:0] pinSync;
  logic       rxLow;
  logic       toneOn;
  logic       calDone;

  lrcoc_sync #(
    .WIDTH (3)
  ) uPins (
    .clk     (clk),
    .rstN    (rstN),
    .asyncIn ({calDoneIn, billingToneIn, rxBelowGround}),
    .syncOut (pinSync)
  );

  assign rxLow   = pinSync[0];
  assign toneOn  = pinSync[1];
  assign calDone = pinSync[2];

  // ============================================================
  // decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  logic wrRing;
  logic wrCal;
  logic wrMask;
  logic wrStat;

  assign wrRing = regWrite && hit(regAddr, `LRCOC_OFS_RING_LINE);
  assign wrCal  = regWrite && hit(regAddr, `LRCOC_OFS_CAL_OVL);
  assign wrMask = regWrite && hit(regAddr, `LRCOC_OFS_IRQ_MASK);
  assign wrStat = regWrite && hit(regAddr, `LRCOC_OFS_IRQ_STAT);

  // ============================================================
  // ring_line_ctrl
  logic ringerImp_q;
  logic ringThresh_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ringerImp_q  <= 1'b0;
      ringThresh_q <= 1'b0;
    end else if (wrRing) begin
      ringerImp_q  <= regWdata[`LRCOC_RL_RZ];
      ringThresh_q <= regWdata[`LRCOC_RL_RT];
    end
  end

  // fixed variants ignore the bit and keep maximum impedance / low window
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ringerImpedanceSynth <= 1'b0;
      ringThresholdHigh    <= 1'b0;
    end else begin
      ringerImpedanceSynth <= HAS_PROG_RINGER && ringerImp_q;
      ringThresholdHigh    <= HAS_RING_THRESH && ringThresh_q;
    end
  end

  lrcoc_ring_cmp uRing (
    .clk        (clk),
    .rstN       (rstN),
    .highWindow (ringThresholdHigh),
    .ringLevel  (ringLevel),
    .ringDetect (ringDetect)
  );

  // ============================================================
  // calibration and overload control bits
  logic clear_calibration_q;
  logic manual_calibration_start_q;
  logic auto_calibration_disable_q;
  logic ope_q;
  logic bte_q;

  // clear-calibration is never self-cleared; software owns it
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      clear_calibration_q <= 1'b0;
      manual_calibration_start_q <= 1'b0;
      auto_calibration_disable_q <= 1'b0;
      ope_q  <= 1'b0;
      bte_q  <= 1'b0;
    end else if (wrCal) begin
      clear_calibration_q <= regWdata[`LRCOC_CO_CLEAR_CALIBRATION];
      manual_calibration_start_q <= regWdata[`LRCOC_CO_MANUAL_CALIBRATION_START];
      auto_calibration_disable_q <= regWdata[`LRCOC_CO_AUTO_CALIBRATION_DISABLE];
      ope_q  <= regWdata[`LRCOC_CO_OPE];
      bte_q  <= regWdata[`LRCOC_CO_BTE];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      calibClear        <= 1'b0;
      autoCalEn         <= 1'b0;
      overloadProtectEn <= 1'b0;
    end else begin
      calibClear        <= clear_calibration_q;
      autoCalEn         <= !auto_calibration_disable_q && !clear_calibration_q;
      overloadProtectEn <= ope_q;
    end
  end

  // ============================================================
  // manual calibration sequencer
  lrcoc_cal_state_t calState_q;
  logic             calFinish;
  logic             calReq;
  logic             calDonePrev_q;
  logic             calDoneRise;

  // a done level left high by the previous run must not end the next one
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      calDonePrev_q <= 1'b0;
    end else begin
      calDonePrev_q <= calDone;
    end
  end

  assign calDoneRise = calDone && !calDonePrev_q;

  // a start while one is running, or while data is being cleared, is dropped
  assign calReq = wrCal && regWdata[`LRCOC_CO_MANUAL_CALIBRATION_START] && !clear_calibration_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      calState_q <= LRCOC_CAL_IDLE;
      calibStart <= 1'b0;
      calFinish  <= 1'b0;
    end else begin
      calibStart <= 1'b0;
      calFinish  <= 1'b0;
      case (calState_q)
        LRCOC_CAL_IDLE: begin
          if (calReq) begin
            calibStart <= 1'b1;
            calState_q <= LRCOC_CAL_RUN;
          end
        end
        LRCOC_CAL_RUN: begin
          if (calDoneRise && !calibStart) begin
            calFinish  <= 1'b1;
            calState_q <= LRCOC_CAL_IDLE;
          end
        end
        default: begin
          calState_q <= LRCOC_CAL_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // billing tone
  logic btd_q;
  logic btSet;

  assign btSet = bte_q && toneOn;

  // the disabling write wins: detection is off from that edge on
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      btd_q <= 1'b0;
    end else if (wrCal && !regWdata[`LRCOC_CO_BTE]) begin
      btd_q <= 1'b0;
    end else if (btSet) begin
      btd_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      offHookHold <= 1'b0;
    end else begin
      offHookHold <= offHookReq || btSet;
    end
  end

  // ============================================================
  // receive overload
  logic rov_q;
  logic rovClr;

  assign rovClr = wrCal && !regWdata[`LRCOC_CO_ROV];

  // writing one leaves the flag alone; a new overload beats the clear
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rov_q <= 1'b0;
    end else if (rxLow) begin
      rov_q <= 1'b1;
    end else if (rovClr) begin
      rov_q <= 1'b0;
    end
  end

  // ============================================================
  // interrupt status and mask
  lrcoc_byte_t irqStat_q;
  lrcoc_byte_t irqMask_q;
  lrcoc_byte_t irqEvt;
  lrcoc_byte_t irqClr;
  logic        btSet_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      btSet_q <= 1'b0;
    end else begin
      btSet_q <= btSet;
    end
  end

  always_comb begin
    irqEvt = 8'h00;
    irqEvt[`LRCOC_IRQ_BT]  = btSet && !btSet_q;
    irqEvt[`LRCOC_IRQ_CAL] = calFinish;
    irqEvt[`LRCOC_IRQ_ROV] = rxLow;
    irqClr = wrStat ? regWdata : 8'h00;
    irqClr[`LRCOC_IRQ_ROV] = irqClr[`LRCOC_IRQ_ROV] || rovClr;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irqStat_q <= `LRCOC_RST_IRQ;
    end else begin
      irqStat_q <= (irqStat_q & ~irqClr) | irqEvt;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irqMask_q <= `LRCOC_RST_IRQ;
    end else if (wrMask) begin
      irqMask_q <= regWdata;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irqStat_q & ~irqClr) | irqEvt) & irqMask_q);
    end
  end

  // ============================================================
  // read back
  lrcoc_byte_t rdMux;

  // reserved bit 4 is given as zero here
  always_comb begin
    rdMux = 8'h00;
    case (regAddr)
      `LRCOC_OFS_RING_LINE: begin
        rdMux[`LRCOC_RL_RZ] = ringerImp_q;
        rdMux[`LRCOC_RL_RT] = ringThresh_q;
      end
      `LRCOC_OFS_CAL_OVL: begin
        rdMux[`LRCOC_CO_CLEAR_CALIBRATION] = clear_calibration_q;
        rdMux[`LRCOC_CO_MANUAL_CALIBRATION_START] = manual_calibration_start_q;
        rdMux[`LRCOC_CO_AUTO_CALIBRATION_DISABLE] = auto_calibration_disable_q;
        rdMux[`LRCOC_CO_OPE]  = ope_q;
        rdMux[`LRCOC_CO_BTE]  = bte_q;
        rdMux[`LRCOC_CO_ROV]  = rov_q;
        rdMux[`LRCOC_CO_BTD]  = btd_q;
      end
      `LRCOC_OFS_IRQ_MASK: begin
        rdMux = irqMask_q;
      end
      `LRCOC_OFS_IRQ_STAT: begin
        rdMux = irqStat_q;
      end
      default: begin
        rdMux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      regRdata <= rdMux;
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule

// ### lrcoc_regs.svh
// register offsets, field positions, reset values and ring window limits
// assumes: included by bare name from the control module, the ring comparator and the checker
`ifndef LRCOC_REGS_SVH
`define LRCOC_REGS_SVH

// ============================================================
// offsets
`define LRCOC_OFS_IRQ_MASK   8'h03
`define LRCOC_OFS_IRQ_STAT   8'h04
`define LRCOC_OFS_RING_LINE  8'h10
`define LRCOC_OFS_CAL_OVL    8'h11

// ============================================================
// ring_line_ctrl fields
`define LRCOC_RL_RT          0
`define LRCOC_RL_RZ          1

// ============================================================
// calib_overload_billing_ctrl fields
`define LRCOC_CO_BTD         0
`define LRCOC_CO_ROV         1
`define LRCOC_CO_BTE         2
`define LRCOC_CO_OPE         3
`define LRCOC_CO_AUTO_CALIBRATION_DISABLE        5
`define LRCOC_CO_MANUAL_CALIBRATION_START        6
`define LRCOC_CO_CLEAR_CALIBRATION        7

// ============================================================
// interrupt status / mask fields
`define LRCOC_IRQ_BT         0
`define LRCOC_IRQ_CAL        1
`define LRCOC_IRQ_ROV        6

// ============================================================
// reset values
`define LRCOC_RST_RING_LINE  8'h00
`define LRCOC_RST_CAL_OVL    8'h00
`define LRCOC_RST_IRQ        8'h00

// ============================================================
// ring windows, millivolts rms
`define LRCOC_RING_LO_MIN    16'd13500
`define LRCOC_RING_LO_MAX    16'd16500
`define LRCOC_RING_HI_MIN    16'd19350
`define LRCOC_RING_HI_MAX    16'd23650

`endif

// ### lrcoc_pkg.sv
// types shared by the line ring / calibration / overload control block
// assumes: numeric constants live in lrcoc_regs.svh
package lrcoc_pkg;

  typedef enum logic {
    LRCOC_CAL_IDLE,
    LRCOC_CAL_RUN
  } lrcoc_cal_state_t;

  typedef logic [7:0] lrcoc_byte_t;

endpackage

// ### lrcoc_sync.sv
// two-flop synchroniser for asynchronous level inputs
// assumes: each bit is an independent level, not a multi-bit word
`timescale 1ns/1ns
module lrcoc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1_q <= '0;
      syncOut  <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end

endmodule

// ### lrcoc_ring_cmp.sv
// ring detect comparator with selectable window and hysteresis
// assumes: ringLevel is a same-clock rms estimate in millivolts
`timescale 1ns/1ns
`include "lrcoc_regs.svh"
module lrcoc_ring_cmp (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstN,
  // control
  input  wire logic        highWindow,
  input  wire logic [15:0] ringLevel,
  // result
  output logic             ringDetect
);

  logic [15:0] winMin;
  logic [15:0] winMax;
  logic [15:0] onLevel;

  // trip at the window midpoint, release below its floor: never below, always above
  always_comb begin
    winMin  = highWindow ? `LRCOC_RING_HI_MIN : `LRCOC_RING_LO_MIN;
    winMax  = highWindow ? `LRCOC_RING_HI_MAX : `LRCOC_RING_LO_MAX;
    onLevel = 16'((32'(winMin) + 32'(winMax)) >> 1);
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ringDetect <= 1'b0;
    end else if (ringLevel < winMin) begin
      ringDetect <= 1'b0;
    end else if (ringLevel >= onLevel) begin
      ringDetect <= 1'b1;
    end
  end

endmodule

// ### lrcoc_ctrl_asserts.sv
// checker for the ring, calibration and overload control registers
// assumes: bound to lrcoc_ctrl; outputs lag rst_n by the internal release flops
`timescale 1ns/1ns
`include "lrcoc_regs.svh"
module lrcoc_ctrl_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regRdata,
  // line side
  input wire logic [15:0] ringLevel,
  input wire logic        offHookReq,
  input wire logic        ringDetect,
  input wire logic        calibClear,
  input wire logic        calibStart,
  input wire logic        autoCalEn,
  input wire logic        offHookHold,
  input wire logic        irq
);
  // ============================================================
  // settle window: checks wait until the internal reset copy is gone
  logic [3:0] upQ;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) upQ <= 4'h0;
    else upQ <= {upQ[2:0], 1'b1};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!upQ[3]);

  // ============================================================
  // properties
  property p_rd_resv;
    regRead && regAddr == `LRCOC_OFS_CAL_OVL |=> !regRdata[4];
  endproperty
  a_rd_resv: assert property (p_rd_resv) else $error("reserved bit read as one");
  property p_clear_calibration;
    regWrite && regAddr == `LRCOC_OFS_CAL_OVL && regWdata[7] |-> ##2 calibClear && !autoCalEn;
  endproperty
  a_clear_calibration: assert property (p_clear_calibration) else $error("clear calibration not applied");
  property p_auto_calibration_disable;
    regWrite && regAddr == `LRCOC_OFS_CAL_OVL && regWdata[5] |-> ##2 !autoCalEn;
  endproperty
  a_auto_calibration_disable: assert property (p_auto_calibration_disable) else $error("auto calibration not suppressed");
  property p_calst;
    calibStart |=> !calibStart;
  endproperty
  a_calst: assert property (p_calst) else $error("calibration start too long");
  property p_hold;
    offHookReq |=> offHookHold;
  endproperty
  a_hold: assert property (p_hold) else $error("off-hook hold dropped");
  property p_irq;
    irq && !regWrite && !$past(regWrite) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt fell without a write");
  property p_ringlo;
    ringLevel < `LRCOC_RING_LO_MIN |=> !ringDetect;
  endproperty
  a_ringlo: assert property (p_ringlo) else $error("ring detected below floor");
  property p_ringhi;
    ringLevel > `LRCOC_RING_HI_MAX |=> ringDetect;
  endproperty
  a_ringhi: assert property (p_ringhi) else $error("ring missed above ceiling");
endmodule

bind lrcoc_ctrl lrcoc_ctrl_asserts chk (.*);

// ### lrcoc_afe_model.sv
// calibration engine stand-in on the analog side of the control block
// assumes: calibStart is a one-cycle pulse on clk
`timescale 1ns/1ns
module lrcoc_afe_model #(
  parameter int DLY = 5
) (
  // clock
  input wire logic clk,
  // calibration handshake
  input wire logic calibStart,
  output logic     calDoneIn
);
  int cnt = -1;
  initial calDoneIn = 1'b0;
  // done stays up until the next start, as a finished engine would report
  always @(posedge clk) begin
    if (calibStart) begin
      calDoneIn <= 1'b0;
      cnt       <= DLY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else if (cnt == 0) begin
      calDoneIn <= 1'b1;
      cnt       <= -1;
    end
  end
endmodule

// ### line_ring_calib_overload_ctrl_bench.sv
// self-checking bench for the ring, calibration and overload control registers
// assumes: the checker is bound from its own file
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module line_ring_calib_overload_ctrl_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWdata = 8'h00;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [7:0]  regRdata;
  logic [15:0] ringLevel = 16'h0000;
  logic        rxBelowGround = 1'b0;
  logic        billingToneIn = 1'b0;
  logic        calDoneIn;
  logic        offHookReq = 1'b0;
  logic        ringerImpedanceSynth, ringThresholdHigh, ringDetect, calibClear;
  logic        calibStart, autoCalEn, overloadProtectEn, offHookHold, irq;
  int          n_fail = 0;
  int          compares = 0;

  always #5 clk = ~clk;

  lrcoc_ctrl uut (.clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .ringLevel, .rxBelowGround, .billingToneIn, .calDoneIn, .offHookReq,
    .ringerImpedanceSynth, .ringThresholdHigh, .ringDetect, .calibClear, .calibStart,
    .autoCalEn, .overloadProtectEn, .offHookHold, .irq);
  lrcoc_afe_model #(.DLY(5)) afe (.clk, .calibStart, .calDoneIn);

  // ============================================================
  // bus and timing helpers
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    `CHK(regRdata, e)
  endtask

  // ============================================================
  // scenarios
  task automatic t_reset;
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h00);
    `CHK(autoCalEn, 1'b1)
  endtask
  task automatic t_ring;
    wr(8'h10, 8'hff);
    wt(3);
    `CHK({ringerImpedanceSynth, ringThresholdHigh}, 2'b11)
    rd(8'h10, 8'h03);
    ringLevel <= 16'd24000;
    wt(3);
    `CHK(ringDetect, 1'b1)
    ringLevel <= 16'd13000;
    wt(3);
    `CHK(ringDetect, 1'b0)
    ringLevel <= 16'd18000;
    wt(3);
    `CHK(ringDetect, 1'b0)
    wr(8'h10, 8'h00);
    wt(3);
    `CHK(ringDetect, 1'b1)
    `CHK({ringerImpedanceSynth, ringThresholdHigh}, 2'b00)
    ringLevel <= 16'h0000;
  endtask
  task automatic t_cal;
    logic seen;
    seen = 1'b0;
    wr(8'h03, 8'h43);
    wr(8'h11, 8'h80);
    wt(3);
    `CHK({calibClear, autoCalEn}, 2'b10)
    wr(8'h11, 8'h00);
    wt(3);
    `CHK({calibClear, autoCalEn}, 2'b01)
    wr(8'h11, 8'h20);
    wt(3);
    `CHK(autoCalEn, 1'b0)
    wr(8'h11, 8'h40);
    // the start pulse stands only in the cycle right after the write edge
    repeat (6) begin
      #1;
      seen = seen | calibStart;
      @(posedge clk);
    end
    `CHK(seen, 1'b1)
    wt(15);
    `CHK(irq, 1'b1)
    rd(8'h04, 8'h02);
    wr(8'h04, 8'h02);
    wt(2);
    `CHK(irq, 1'b0)
    wr(8'h11, 8'h18);
    wt(3);
    `CHK(overloadProtectEn, 1'b1)
    rd(8'h11, 8'h08);
    wr(8'h11, 8'h00);
  endtask
  task automatic t_bill;
    wr(8'h11, 8'h05);
    rd(8'h11, 8'h04);
    billingToneIn <= 1'b1;
    wt(5);
    `CHK(offHookHold, 1'b1)
    `CHK(irq, 1'b1)
    rd(8'h11, 8'h05);
    wr(8'h04, 8'h01);
    wt(2);
    `CHK(irq, 1'b0)
    wr(8'h11, 8'h00);
    rd(8'h11, 8'h00);
    wt(3);
    rd(8'h11, 8'h00);
    `CHK(offHookHold, 1'b0)
    billingToneIn <= 1'b0;
    offHookReq    <= 1'b1;
    wt(2);
    `CHK(offHookHold, 1'b1)
    offHookReq <= 1'b0;
  endtask
  task automatic t_rov;
    wr(8'h03, 8'h00);
    rxBelowGround <= 1'b1;
    wt(3);
    rxBelowGround <= 1'b0;
    wt(4);
    rd(8'h11, 8'h02);
    `CHK(irq, 1'b0)
    wr(8'h03, 8'h40);
    wt(2);
    `CHK(irq, 1'b1)
    wr(8'h11, 8'h02);
    rd(8'h11, 8'h02);
    wr(8'h11, 8'h00);
    wt(2);
    `CHK(irq, 1'b0)
    rd(8'h04, 8'h00);
    rd(8'h11, 8'h00);
    wr(8'h22, 8'hff);
    rd(8'h22, 8'h00);
  endtask

  // ============================================================
  // run control
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wt(3);
    t_reset;
    t_ring;
    t_cal;
    t_bill;
    t_rov;
    report_and_stop;
  end

  // the sequence needs well under a thousand cycles
  initial begin
    #100000;
    n_fail++;
    report_and_stop;
  end
endmodule
